// ===== common/fpc_pkg.sv
// constants and types for the flash program controller
package fpc_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_KEY     = 8'h04;
  localparam logic [7:0]  OFS_ADDR    = 8'h08;
  localparam logic [7:0]  OFS_DATA    = 8'h0C;
  localparam logic [7:0]  OFS_SRC     = 8'h10;
  // control register bit positions
  localparam int          START_BIT   = 15;
  localparam int          ARM_BIT     = 14;
  localparam int          FAIL_BIT    = 13;
  localparam int          LOWF_BIT    = 12;
  localparam int          LOWN_BIT    = 11;
  localparam int          OPSEL_LSB   = 0;
  localparam int          OPSEL_MSB   = 3;
  // operation select codes
  localparam logic [3:0]  OP_NONE     = 4'h0;
  localparam logic [3:0]  OP_WORD     = 4'h1;
  localparam logic [3:0]  OP_ROW      = 4'h3;
  localparam logic [3:0]  OP_PAGE     = 4'h4;
  localparam logic [3:0]  OP_ALL      = 4'h5;
  // unlock keys, arbitrary values, written in this order
  localparam logic [31:0] KEY_FIRST   = 32'h0F0F1234;
  localparam logic [31:0] KEY_SECOND  = 32'h4321F0F0;
  // unlock progress count meaning fully unlocked
  localparam logic [1:0]  KEY_DONE    = 2'h2;
  // reset values
  localparam logic [31:0] RST_WORD    = 32'h00000000;
  localparam logic [3:0]  RST_OP      = 4'h0;
  localparam logic [1:0]  RST_STAGE   = 2'h0;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } fpc_state_e;
endpackage

// ===== verilog/fpc_flash_program_controller.sv
// flash program controller: registers, unlock guard and operation sequencer
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
module fpc_flash_program_controller (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             flash_req,
  output logic      [3:0]  flash_op,
  output logic      [31:0] flash_addr,
  output logic      [31:0] flash_data,
  output logic      [31:0] flash_src,
  input  wire logic        flash_done,
  input  wire logic        flash_ok,
  input  wire logic        target_protected,
  input  wire logic        any_protected,
  input  wire logic        supply_low_pin,
  output logic             droop_detect_en
);

  // true for codes that touch the array
  function automatic logic is_real_op(input logic [3:0] op);
    is_real_op = (op == fpc_pkg::OP_WORD) || (op == fpc_pkg::OP_ROW) ||
                 (op == fpc_pkg::OP_PAGE) || (op == fpc_pkg::OP_ALL);
  endfunction

  logic             arm;          // write-arm bit
  logic             start;        // operation start bit
  logic             fail;         // operation failure flag
  logic             lowf;         // low-supply failure flag
  logic      [3:0]  op_sel;       // operation select field
  logic      [1:0]  key_stage;    // unlock progress
  logic      [31:0] target;       // target location register
  logic      [31:0] pword;        // program word register
  logic      [31:0] src_ptr;      // row source pointer register
  logic             low_meta;     // synchroniser first stage
  logic             low_sync;     // synchronised supply-low level
  logic             low_now;      // live low-supply status
  fpc_pkg::fpc_state_e state;     // sequencer state
  logic             wr_ctrl;      // decoded register writes
  logic             wr_key;
  logic             wr_addr;
  logic             wr_data;
  logic             wr_src;
  logic             start_ok;     // start write honoured
  logic             prot;         // selected target protected
  logic             real_op;      // selected code is a real op
  logic             set_fail;
  logic             clr_flags;
  logic             set_lowf;
  logic      [31:0] rd_val;       // read mux value

  // write address decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_key  = 1'b0;
    wr_addr = 1'b0;
    wr_data = 1'b0;
    wr_src  = 1'b0;
    if (addr == fpc_pkg::OFS_CTRL) begin
      wr_ctrl = wr;
    end else if (addr == fpc_pkg::OFS_KEY) begin
      wr_key = wr;
    end else if (addr == fpc_pkg::OFS_ADDR) begin
      wr_addr = wr;
    end else if (addr == fpc_pkg::OFS_DATA) begin
      wr_data = wr;
    end else if (addr == fpc_pkg::OFS_SRC) begin
      wr_src = wr;
    end
  end

  // supply-low pin two-stage synchroniser
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      low_meta <= 1'b0;
      low_sync <= 1'b0;
    end else if (ce) begin
      low_meta <= supply_low_pin;
      low_sync <= low_meta;
    end
  end

  assign low_now = low_sync & arm;
  assign droop_detect_en = arm;

  // arm bit, cleared by either reset
  always_ff @(posedge clk or negedge rst_n or negedge por_n) begin
    if (!rst_n || !por_n) begin
      arm <= 1'b0;
    end else if (ce && wr_ctrl) begin
      arm <= wdata[fpc_pkg::ARM_BIT];
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      op_sel <= fpc_pkg::RST_OP;
    end else if (ce && wr_ctrl && !arm) begin
      op_sel <= wdata[fpc_pkg::OPSEL_MSB:fpc_pkg::OPSEL_LSB];
    end
  end

  // ordered keys, any other write restarts
  always_ff @(posedge clk or negedge rst_n or negedge por_n) begin
    if (!rst_n || !por_n) begin
      key_stage <= fpc_pkg::RST_STAGE;
    end else if (ce && wr) begin
      if (wr_key && key_stage == fpc_pkg::RST_STAGE &&
          wdata == fpc_pkg::KEY_FIRST) begin
        key_stage <= 2'h1;
      end else if (wr_key && key_stage == 2'h1 &&
                   wdata == fpc_pkg::KEY_SECOND) begin
        key_stage <= fpc_pkg::KEY_DONE;
      end else begin
        // wrong key or any other write relocks
        key_stage <= fpc_pkg::RST_STAGE;
      end
    end
  end

  // start honoured only armed and unlocked
  assign start_ok = wr_ctrl && wdata[fpc_pkg::START_BIT] && arm &&
                    key_stage == fpc_pkg::KEY_DONE &&
                    state == fpc_pkg::ST_IDLE && !start;

  // full erase checks array, not target
  assign prot = (op_sel == fpc_pkg::OP_ALL) ? any_protected : target_protected;
  // only codes 1,3,4,5 reach the array
  assign real_op = is_real_op(op_sel);

  // location and data registers
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      target <= fpc_pkg::RST_WORD;
    end else if (ce && wr_addr) begin
      target <= wdata;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      pword <= fpc_pkg::RST_WORD;
    end else if (ce && wr_data) begin
      pword <= wdata;
    end
  end

  // row source pointer for row program
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      src_ptr <= fpc_pkg::RST_WORD;
    end else if (ce && wr_src) begin
      src_ptr <= wdata;
    end
  end

  // array side outputs straight from registers
  assign flash_op   = op_sel;
  assign flash_addr = target;
  assign flash_data = pword;
  assign flash_src  = src_ptr;

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      state     <= fpc_pkg::ST_IDLE;
      start     <= 1'b0;
      flash_req <= 1'b0;
    end else if (ce) begin
      flash_req <= 1'b0;
      case (state)
        fpc_pkg::ST_IDLE: begin
          if (start_ok) begin
            start <= 1'b1;
            state <= fpc_pkg::ST_ISSUE;
          end
        end
        fpc_pkg::ST_ISSUE: begin
          if (!real_op) begin
            start <= 1'b0;
            state <= fpc_pkg::ST_IDLE;
          end else if (prot) begin
            start <= 1'b0;
            state <= fpc_pkg::ST_IDLE;
          end else begin
            flash_req <= 1'b1;
            state     <= fpc_pkg::ST_WAIT;
          end
        end
        fpc_pkg::ST_WAIT: begin
          // array finished, drop start
          if (flash_done) begin
            start <= 1'b0;
            state <= fpc_pkg::ST_IDLE;
          end
        end
        default: begin
          start <= 1'b0;
          state <= fpc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign set_fail = (state == fpc_pkg::ST_ISSUE && real_op && prot) ||
                    (state == fpc_pkg::ST_WAIT && flash_done && !flash_ok);
  assign clr_flags = state == fpc_pkg::ST_ISSUE && op_sel == fpc_pkg::OP_NONE;
  assign set_lowf = state == fpc_pkg::ST_WAIT && low_now;

  // sticky flags, set wins over clear
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      fail <= 1'b0;
      lowf <= 1'b0;
    end else if (ce) begin
      fail <= set_fail || (fail && !clr_flags);
      lowf <= set_lowf || (lowf && !clr_flags);
    end
  end

  // read mux
  always_comb begin
    rd_val = fpc_pkg::RST_WORD;
    if (addr == fpc_pkg::OFS_CTRL) begin
      rd_val[fpc_pkg::START_BIT] = start;
      rd_val[fpc_pkg::ARM_BIT]   = arm;
      rd_val[fpc_pkg::FAIL_BIT]  = fail;
      rd_val[fpc_pkg::LOWF_BIT]  = lowf;
      rd_val[fpc_pkg::LOWN_BIT]  = low_now;
      rd_val[fpc_pkg::OPSEL_MSB:fpc_pkg::OPSEL_LSB] = op_sel;
    end else if (addr == fpc_pkg::OFS_KEY) begin
      rd_val = fpc_pkg::RST_WORD;
    end else if (addr == fpc_pkg::OFS_ADDR) begin
      rd_val = target;
    end else if (addr == fpc_pkg::OFS_DATA) begin
      rd_val = pword;
    end else if (addr == fpc_pkg::OFS_SRC) begin
      rd_val = src_ptr;
    end
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n or negedge por_n) begin
    if (!rst_n || !por_n) begin
      rdata <= fpc_pkg::RST_WORD;
    end else if (ce) begin
      rdata <= rd ? rd_val : fpc_pkg::RST_WORD;
    end
  end

  // checks on the logic above
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !por_n);

  // launch with a real, unprotected code
  sequence seq_launch;
    ce && state == fpc_pkg::ST_ISSUE && real_op && !prot;
  endsequence

  // array answer while waiting
  sequence seq_finish;
    ce && state == fpc_pkg::ST_WAIT && flash_done;
  endsequence

  start_gate_a: assert property (start && !$past(start) |->
    $past(arm) && $past(key_stage) == fpc_pkg::KEY_DONE)
    else $error("start set without arm and unlock");

  launch_req_a: assert property (seq_launch |=> flash_req &&
    state == fpc_pkg::ST_WAIT && start)
    else $error("launch did not request array");

  finish_clr_a: assert property (seq_finish |=> !start &&
    state == fpc_pkg::ST_IDLE)
    else $error("start not cleared after finish");

  disarm_block_a: assert property (ce && wr_ctrl && !arm |=>
    !$rose(start))
    else $error("start changed while disarmed");

  fail_set_a: assert property (seq_finish and !flash_ok |=> fail)
    else $error("failed op left flag clear");

  low_fail_a: assert property (ce && set_lowf |=> lowf)
    else $error("low supply during program not flagged");

  low_read_a: assert property (rd && addr == fpc_pkg::OFS_CTRL && ce |=>
    rdata[fpc_pkg::LOWN_BIT] == $past(arm && low_sync))
    else $error("live low-supply bit wrong");

  flag_clr_a: assert property (ce && clr_flags |=> !fail && !lowf)
    else $error("flags not cleared by code zero");

  op_lock_a: assert property (ce && wr_ctrl && arm |=> $stable(op_sel))
    else $error("op select changed while armed");

  key_read_a: assert property (ce && rd && addr == fpc_pkg::OFS_KEY |=>
    rdata == fpc_pkg::RST_WORD)
    else $error("key register read nonzero");

  rsvd_zero_a: assert property (ce && rd && addr == fpc_pkg::OFS_CTRL |=>
    rdata[31:16] == 16'h0000 && rdata[10:4] == 7'h00)
    else $error("unimplemented control bits nonzero");

  protect_a: assert property (ce && state == fpc_pkg::ST_ISSUE &&
    real_op && prot |=> fail && !flash_req ##1 !flash_req)
    else $error("protected target not refused");

endmodule

// ===== verif/test_flash_program_controller.sv
// self-checking bench for the flash program controller
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_flash_program_controller;
  logic        clk;
  logic        rst_n;
  logic        por_n;
  logic        ce;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        flash_req;
  logic [3:0]  flash_op;
  logic [31:0] flash_addr;
  logic [31:0] flash_data;
  logic [31:0] flash_src;
  logic        flash_done;
  logic        flash_ok;
  logic        target_protected;
  logic        any_protected;
  logic        supply_low_pin;
  logic        droop_detect_en;
  int          fail_count;
  int          checked;
  int          reqs;     // launch pulses seen
  int          n;        // req count before a step
  fpc_flash_program_controller fpc_flash_program_controller_inst (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .flash_req(flash_req), .flash_op(flash_op),
    .flash_addr(flash_addr), .flash_data(flash_data), .flash_src(flash_src),
    .flash_done(flash_done), .flash_ok(flash_ok), .target_protected(target_protected),
    .any_protected(any_protected), .supply_low_pin(supply_low_pin),
    .droop_detect_en(droop_detect_en));
  // free-running clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count launch pulses to the array
  always @(posedge clk) begin
    if (flash_req === 1'b1) reqs++;
  end
  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  // disarm, load op code, re-arm
  task automatic set_op(input logic [3:0] op);
    wr_reg(fpc_pkg::OFS_CTRL, {28'h0000000, op});
    wr_reg(fpc_pkg::OFS_CTRL, {28'h0000000, op});
    wr_reg(fpc_pkg::OFS_CTRL, {28'h0000400, op});
  endtask
  // key pair then control write, then let the launch settle
  task automatic launch(input logic [31:0] v);
    wr_reg(fpc_pkg::OFS_KEY, fpc_pkg::KEY_FIRST);
    wr_reg(fpc_pkg::OFS_KEY, fpc_pkg::KEY_SECOND);
    wr_reg(fpc_pkg::OFS_CTRL, v);
    repeat (4) @(posedge clk);
  endtask
  // array reports completion for one cycle
  task automatic op_done(input logic ok);
    @(posedge clk);
    flash_ok <= ok;
    flash_done <= 1'b1;
    @(posedge clk);
    flash_done <= 1'b0;
  endtask
  // verdict and end of run
  task automatic end_sim();
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  // main sequence
  initial begin
    {rst_n, por_n, wr, rd, flash_done, flash_ok} = '0;
    {target_protected, any_protected, supply_low_pin} = '0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h00000000;
    fail_count = 0;
    checked = 0;
    reqs = 0;
    repeat (5) @(posedge clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00000000);
    wr_reg(fpc_pkg::OFS_KEY, 32'hFFFFFFFF);
    rd_chk(fpc_pkg::OFS_KEY, 32'h00000000);
    rd_chk(8'h20, 32'h00000000);
    // location, word and source registers
    wr_reg(fpc_pkg::OFS_ADDR, 32'hA5A50F0F);
    wr_reg(fpc_pkg::OFS_DATA, 32'h12345678);
    wr_reg(fpc_pkg::OFS_SRC, 32'h80001000);
    ce <= 1'b0;
    wr_reg(fpc_pkg::OFS_ADDR, 32'h00000000);
    ce <= 1'b1;
    rd_chk(fpc_pkg::OFS_ADDR, 32'hA5A50F0F);
    rd_chk(fpc_pkg::OFS_SRC, 32'h80001000);
    `CHK(flash_data, 32'h12345678)
    `CHK(flash_src, 32'h80001000)
    // unimplemented and read-only bits, start while disarmed
    wr_reg(fpc_pkg::OFS_CTRL, 32'hFFFFBFF1);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00000001);
    wr_reg(fpc_pkg::OFS_CTRL, 32'h00004001);
    // let the arm write settle before looking at the pin
    @(negedge clk);
    `CHK(droop_detect_en, 1'b1)
    wr_reg(fpc_pkg::OFS_CTRL, 32'h00004003);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00004001);
    wr_reg(fpc_pkg::OFS_CTRL, 32'h0000C001);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00004001);
    // keys reversed, then a write between the keys
    wr_reg(fpc_pkg::OFS_KEY, fpc_pkg::KEY_SECOND);
    wr_reg(fpc_pkg::OFS_KEY, fpc_pkg::KEY_FIRST);
    wr_reg(fpc_pkg::OFS_CTRL, 32'h0000C001);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00004001);
    wr_reg(fpc_pkg::OFS_KEY, fpc_pkg::KEY_FIRST);
    wr_reg(fpc_pkg::OFS_ADDR, 32'hA5A50F0F);
    wr_reg(fpc_pkg::OFS_KEY, fpc_pkg::KEY_SECOND);
    wr_reg(fpc_pkg::OFS_CTRL, 32'h0000C001);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00004001);
    `CHK(reqs, 0)
    // word program, success then failure
    launch(32'h0000C001);
    `CHK(reqs, 1)
    `CHK(flash_addr, 32'hA5A50F0F)
    rd_chk(fpc_pkg::OFS_CTRL, 32'h0000C001);
    op_done(1'b1);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00004001);
    launch(32'h0000C001);
    op_done(1'b0);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00006001);
    // code zero clears the failure flag
    set_op(4'h0);
    launch(32'h0000C000);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00004000);
    // codes that do nothing
    for (int c = 2; c < 16; c++) begin
      if (c == 3 || c == 4 || c == 5) continue;
      set_op(c[3:0]);
      launch({16'h0000, 12'hC00, c[3:0]});
      rd_chk(fpc_pkg::OFS_CTRL, {16'h0000, 12'h400, c[3:0]});
    end
    `CHK(reqs, 2)
    // protected word is refused
    set_op(4'h1);
    target_protected <= 1'b1;
    launch(32'h0000C001);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00006001);
    `CHK(reqs, 2)
    target_protected <= 1'b0;
    // row program and page erase
    for (int c = 3; c < 5; c++) begin
      set_op(c[3:0]);
      launch({16'h0000, 12'hC00, c[3:0]});
      `CHK(flash_op, c[3:0])
      op_done(1'b1);
    end
    `CHK(reqs, 4)
    // full erase ignores the addressed protection, not array protection
    set_op(4'h5);
    target_protected <= 1'b1;
    launch(32'h0000C005);
    `CHK(reqs, 5)
    op_done(1'b1);
    // clear the sticky flag so the refusal must set it again
    set_op(4'h0);
    launch(32'h0000C000);
    set_op(4'h5);
    any_protected <= 1'b1;
    launch(32'h0000C005);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00006005);
    `CHK(reqs, 5)
    {target_protected, any_protected} <= 2'b00;
    // low supply live status and sticky flag
    set_op(4'h0);
    launch(32'h0000C000);
    set_op(4'h1);
    supply_low_pin <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00004801);
    launch(32'h0000C001);
    op_done(1'b1);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00005801);
    wr_reg(fpc_pkg::OFS_CTRL, 32'h00000001);
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00001001);
    `CHK(droop_detect_en, 1'b0)
    supply_low_pin <= 1'b0;
    // device reset clears the arm bit and unlock progress, not flags or data; power-on clears all
    wr_reg(fpc_pkg::OFS_CTRL, 32'h00004001);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00001001);
    rd_chk(fpc_pkg::OFS_DATA, 32'h12345678);
    por_n <= 1'b0;
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    rd_chk(fpc_pkg::OFS_CTRL, 32'h00000000);
    rd_chk(fpc_pkg::OFS_DATA, 32'h00000000);
    end_sim();
  end
endmodule
